//--- logic/doac_top.sv
// Purpose: offset auto-calibration control, status and reference switch
// Assumes: comparator input reports the sign of the output offset during calibration
// Notes: pins may float; a float flag per pin selects the internal pull level
`timescale 1ns/1ns
module doac_top #(
  parameter int STEP_CYCLES = doac_pkg::CAL_STEP_CYCLES // cycles per correction step
) (
  input wire logic core_clk, // system clock, 100 MHz
  input wire logic arst_n, // power-on reset, active low
  input wire logic async_reset_n_pin, // register reset pin level
  input wire logic async_reset_n_float, // register reset pin undriven
  input wire logic power_down_n_pin, // standby pin level
  input wire logic power_down_n_float, // standby pin undriven
  input wire logic cs_n_pin, // chip select pin level
  input wire logic cs_n_float, // chip select undriven
  input wire logic sclk_pin, // serial clock pin level
  input wire logic sclk_float, // serial clock undriven
  input wire logic sdin_pin, // serial data pin level
  input wire logic sdin_float, // serial data undriven
  input wire logic offset_high, // analog: output offset above target
  output logic sdout, // serial data out
  output logic sdout_oe, // serial data out drive enable
  output logic reference_supply_switch, // switch level, analog supply when driven
  output logic reference_supply_switch_oe, // switch closed to analog supply
  output logic [2:0] calibration_loop_switches, // high = switch closed
  output logic cal_feedback_en, // calibration feedback enable
  output logic [15:0] applied_code, // code driving the modulator
  output logic [7:0] applied_correction // correction driving the offset trim
);
  typedef struct packed {
    doac_pkg::doac_cal_state_t st;
    logic cal_done;
    logic [5:0] misc;
    logic [7:0] corr;
    logic [15:0] code;
    logic [15:0] applied;
    logic [15:0] timer;
    logic first;
    logic dir_up;
    logic pdn_q;
    logic ref_oe;
    logic [2:0] loop_sw;
    logic fb_en;
  } doac_top_t;

  doac_top_t r;
  doac_top_t next_r;
  logic arn;
  logic power_down_n;
  logic cs_n;
  logic sclk;
  logic sdin;
  logic rd_req;
  logic wr_req;
  logic [6:0] addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic spi_sdo;
  logic spi_sdo_oe;
  logic launch;
  logic step_due;

  ////////////////////////////////////////////////////////////////
  // pin pulls: a floating board leaves the part out of reset and in standby
  assign arn = async_reset_n_float ? doac_pkg::PULL_ARST_N : async_reset_n_pin;
  assign power_down_n = power_down_n_float ? doac_pkg::PULL_PDN : power_down_n_pin;
  assign cs_n = cs_n_float ? doac_pkg::PULL_CS_N : cs_n_pin;
  // sclk and sdin pulls only keep an idle bus quiet
  assign sclk = sclk_float ? doac_pkg::PULL_SCLK : sclk_pin;
  assign sdin = sdin_float ? doac_pkg::PULL_SDIN : sdin_pin;

  // serial port sees power-on reset only, so a frame in flight survives the reset pin
  doac_spi_slave u_spi (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdin(sdin),
    .rd_data(rd_data),
    .rd_req(rd_req),
    .wr_req(wr_req),
    .addr(addr),
    .wr_data(wr_data),
    .sdo(spi_sdo),
    .sdo_oe(spi_sdo_oe)
  );

  ////////////////////////////////////////////////////////////////
  // read mux; launch bit always reads zero, status is read-only
  always_comb begin
    // default zero covers unmapped indices and the register reset
    rd_data = 16'h0000;
    if (arn) begin
      if (addr == doac_pkg::ADDR_CAL_CONFIG) begin
        rd_data[doac_pkg::CFG_CORR_MSB:doac_pkg::CFG_CORR_LSB] = r.corr;
        rd_data[doac_pkg::CFG_MISC_MSB:doac_pkg::CFG_MISC_LSB] = r.misc;
        rd_data[doac_pkg::CFG_STATUS_BIT] = r.cal_done;
      end else if (addr == doac_pkg::ADDR_DAC_CODE) begin
        rd_data = r.code;
      end
    end
  end

  // a launch in the wake-up cycle is folded into that same run
  // launch honoured only when out of reset, awake and idle
  assign launch = wr_req && arn && addr == doac_pkg::ADDR_CAL_CONFIG
    && wr_data[doac_pkg::CFG_LAUNCH_BIT] && power_down_n
    && r.st == doac_pkg::CAL_IDLE;
  // step length trades comparator settling against total run time
  assign step_due = r.timer == 16'(STEP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////
  // registers, calibration sequencer and pin outputs
  always_comb begin
    next_r = r;
    // previous standby level, for the wake edge
    next_r.pdn_q = power_down_n;
    next_r.ref_oe = power_down_n & arn;
    // register writes; the data register may change during calibration
    if (wr_req && arn) begin
      if (addr == doac_pkg::ADDR_CAL_CONFIG) begin
        next_r.misc = wr_data[doac_pkg::CFG_MISC_MSB:doac_pkg::CFG_MISC_LSB];
      end else if (addr == doac_pkg::ADDR_DAC_CODE) begin
        next_r.code = wr_data;
      end
    end
    // read clears the status; a set in the same cycle wins below
    if (rd_req && addr == doac_pkg::ADDR_CAL_CONFIG) begin
      next_r.cal_done = 1'b0;
    end
    unique case (r.st)
      doac_pkg::CAL_IDLE: begin
        // code follows the register directly outside calibration
        next_r.applied = next_r.code;
        if (launch || (power_down_n && !r.pdn_q && arn)) begin
          next_r.st = doac_pkg::CAL_RUN;
          next_r.corr = doac_pkg::CORR_ZERO;
          next_r.timer = 16'h0000;
          next_r.first = 1'b1;
          next_r.loop_sw = 3'b000;
          next_r.fb_en = 1'b1;
          next_r.applied = r.applied; // output held by the filter caps
        end
      end
      doac_pkg::CAL_RUN: begin
        // one comparator decision per step; the filter caps hold the output meanwhile
        next_r.timer = r.timer + 16'h0001;
        if (!power_down_n || !arn) begin
          // standby aborts: no result, loop restored
          next_r.st = doac_pkg::CAL_IDLE;
          next_r.loop_sw = 3'b111;
          next_r.fb_en = 1'b0;
        end else if (step_due) begin
          next_r.timer = 16'h0000;
          next_r.first = 1'b0;
          // first decision fixes the direction for the whole run
          if (r.first) begin
            next_r.dir_up = ~offset_high;
          end
          if (!r.first && offset_high == r.dir_up) begin
            // comparator flipped: converged at current step
            next_r.st = doac_pkg::CAL_IDLE;
          end else if (offset_high && r.corr == doac_pkg::CORR_NEG_LIMIT) begin
            next_r.corr = doac_pkg::CORR_FAIL_NEG;
            next_r.st = doac_pkg::CAL_IDLE;
          end else if (!offset_high && r.corr == doac_pkg::CORR_POS_LIMIT) begin
            next_r.corr = doac_pkg::CORR_FAIL_POS;
            next_r.st = doac_pkg::CAL_IDLE;
          end else if (offset_high) begin
            next_r.corr = r.corr - 8'h01;
          end else begin
            next_r.corr = r.corr + 8'h01;
          end
          if (next_r.st == doac_pkg::CAL_IDLE) begin
            next_r.cal_done = 1'b1;
            next_r.loop_sw = 3'b111;
            next_r.fb_en = 1'b0;
            next_r.applied = next_r.code;
          end
        end
      end
    endcase
    // reset pin low holds the register set at defaults
    // kept last so it overrides any write or result of this cycle
    if (!arn) begin
      next_r.misc = doac_pkg::MISC_RESET;
      next_r.code = doac_pkg::DAC_CODE_RESET;
      next_r.corr = doac_pkg::CORR_ZERO;
      next_r.cal_done = 1'b0;
    end
  end

  // state register; power-on reset puts the loop back in normal operation
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{
        st: doac_pkg::CAL_IDLE,
        cal_done: 1'b0,
        misc: doac_pkg::MISC_RESET,
        corr: doac_pkg::CORR_ZERO,
        code: doac_pkg::DAC_CODE_RESET,
        applied: doac_pkg::DAC_CODE_RESET,
        timer: 16'h0000,
        first: 1'b0,
        dir_up: 1'b0,
        pdn_q: 1'b0,
        ref_oe: 1'b0,
        loop_sw: 3'b111,
        fb_en: 1'b0
      };
    end else begin
      r <= next_r;
    end
  end

  // ports below are register bits only, no gating after the flops
  assign sdout = spi_sdo;
  assign sdout_oe = spi_sdo_oe;
  assign reference_supply_switch = r.ref_oe;
  assign reference_supply_switch_oe = r.ref_oe;
  assign calibration_loop_switches = r.loop_sw;
  assign cal_feedback_en = r.fb_en;
  assign applied_code = r.applied;
  assign applied_correction = r.corr;
endmodule : doac_top

//--- logic/doac_pkg.sv
// Purpose: constants shared by the offset auto-calibration control and its serial port
// Assumes: one 100 MHz clock, all pins synchronous to it
// Notes: frame is 8-bit header (bit 7 = read, 6:0 = address) then 16 data bits, msb first
// Operation
// - floating reset, standby, select pins pull inactive-safe
// - calibration starts only on launch bit write or power-down release
// - bounded stepped correction, out of range fails
// - correction byte readable in config upper byte
// - 128 zero, 1..127 negative, 129..254 positive, 0/255 fail
// - calibration opens loop switches, enables feedback
// - code written during calibration applied at end
// - status bit read-only, zero after reset and after a read until a run finishes
// - status set at finish, cleared by read
// - power-down release runs calibration automatically
// - reference switch on only when both pins high
// - launch ignored while in standby
// - reset pin low: no writes, reads zero
package doac_pkg;
  // register indices
  localparam logic [6:0] ADDR_CAL_CONFIG = 7'h01;
  localparam logic [6:0] ADDR_DAC_CODE = 7'h02;
  // calibration_config field positions
  localparam int CFG_STATUS_BIT = 0;
  localparam int CFG_LAUNCH_BIT = 1;
  localparam int CFG_MISC_LSB = 2;
  localparam int CFG_MISC_MSB = 7;
  localparam int CFG_CORR_LSB = 8;
  localparam int CFG_CORR_MSB = 15;
  // values after reset
  localparam logic [15:0] DAC_CODE_RESET = 16'h0000;
  localparam logic [5:0] MISC_RESET = 6'h00;
  // correction byte encoding
  localparam logic [7:0] CORR_ZERO = 8'h80;
  localparam logic [7:0] CORR_NEG_LIMIT = 8'h01;
  localparam logic [7:0] CORR_POS_LIMIT = 8'hfe;
  localparam logic [7:0] CORR_FAIL_NEG = 8'h00;
  localparam logic [7:0] CORR_FAIL_POS = 8'hff;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_STEP_US = 250;
  localparam int CAL_STEP_CYCLES = (CAL_STEP_US * 1000) / CLK_PERIOD_NS;
  localparam int CAL_TIMEOUT_MS = 40;
  // serial frame
  localparam logic [4:0] SPI_HDR_BITS = 5'd8;
  localparam logic [4:0] SPI_FRAME_BITS = 5'd24;
  // pull defaults of floating pins
  localparam logic PULL_ARST_N = 1'b1;
  localparam logic PULL_PDN = 1'b0;
  localparam logic PULL_CS_N = 1'b1;
  localparam logic PULL_SCLK = 1'b0;
  localparam logic PULL_SDIN = 1'b0;
  // calibration states
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } doac_cal_state_t;
endpackage : doac_pkg

//--- logic/doac_spi_slave.sv
// Purpose: serial register port, mode 0, one frame per select low period
// Assumes: sclk and sdin sampled on core_clk, sclk much slower than core_clk
// Notes: read data is captured when the header completes
`timescale 1ns/1ns
module doac_spi_slave (
  input wire logic core_clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic cs_n, // resolved chip select
  input wire logic sclk, // resolved serial clock
  input wire logic sdin, // resolved serial data in
  input wire logic [15:0] rd_data, // register value for a read
  output logic rd_req, // pulse: read header complete
  output logic wr_req, // pulse: write frame complete
  output logic [6:0] addr, // register index of frame
  output logic [15:0] wr_data, // write data
  output logic sdo, // serial data out
  output logic sdo_oe // serial data out drive enable
);
  typedef struct packed {
    logic sclk_q;
    logic [4:0] cnt;
    logic [7:0] hdr;
    logic [15:0] sh;
    logic sdo;
    logic sdo_oe;
    logic rd_req;
    logic wr_req;
  } doac_spi_t;

  doac_spi_t r;
  doac_spi_t next_r;
  logic rise;
  logic fall;

  assign rise = sclk & ~r.sclk_q;
  assign fall = ~sclk & r.sclk_q;

  ////////////////////////////////////////////////////////////////
  // frame engine
  always_comb begin
    next_r = r;
    next_r.sclk_q = sclk;
    next_r.rd_req = 1'b0;
    next_r.wr_req = 1'b0;
    if (cs_n) begin
      // deselect aborts any partial frame
      next_r.cnt = 5'd0;
      next_r.sdo_oe = 1'b0;
      next_r.sdo = 1'b0;
    end else begin
      if (rise && r.cnt < doac_pkg::SPI_FRAME_BITS) begin
        next_r.cnt = r.cnt + 5'd1;
        if (r.cnt < doac_pkg::SPI_HDR_BITS) begin
          next_r.hdr = {r.hdr[6:0], sdin};
        end else if (!r.hdr[7]) begin
          next_r.sh = {r.sh[14:0], sdin};
        end
        if (r.cnt == doac_pkg::SPI_HDR_BITS - 5'd1) begin
          next_r.rd_req = sdin ? 1'b0 : 1'b0;
        end
        if (r.cnt == doac_pkg::SPI_FRAME_BITS - 5'd1 && !r.hdr[7]) begin
          next_r.wr_req = 1'b1;
        end
      end
      // header done: fetch read data one cycle later via rd_req
      if (r.cnt == doac_pkg::SPI_HDR_BITS && r.sclk_q && !rise && r.hdr[7] && !r.sdo_oe && !r.rd_req) begin
        next_r.rd_req = 1'b1;
      end
      if (r.rd_req) begin
        next_r.sh = rd_data;
        next_r.sdo = rd_data[15];
        next_r.sdo_oe = 1'b1;
      end
      // shift out on falling edges of the data phase
      if (fall && r.hdr[7] && r.sdo_oe && r.cnt > doac_pkg::SPI_HDR_BITS) begin
        next_r.sh = {r.sh[14:0], 1'b0};
        next_r.sdo = r.sh[14];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rd_req = r.rd_req;
  assign wr_req = r.wr_req;
  assign addr = r.hdr[6:0];
  assign wr_data = r.sh;
  assign sdo = r.sdo;
  assign sdo_oe = r.sdo_oe;
endmodule : doac_spi_slave

//--- dv/doac_top_asserts.sv
// Purpose: port-level checks of calibration control and reference switch
// Assumes: undriven pins resolve to their pull levels through the float flags
// Notes: attached to doac_top by the bind at the foot of this file
`timescale 1ns/1ns
module doac_top_asserts #(
  parameter int STEP_CYCLES = 8 // cycles per correction step
) (
  input wire logic core_clk, // system clock
  input wire logic arst_n, // power-on reset, active low
  input wire logic async_reset_n_pin, // register reset pin level
  input wire logic async_reset_n_float, // register reset pin undriven
  input wire logic power_down_n_pin, // standby pin level
  input wire logic power_down_n_float, // standby pin undriven
  input wire logic cs_n_pin, // chip select level
  input wire logic cs_n_float, // chip select undriven
  input wire logic sdout_oe, // serial out enable
  input wire logic reference_supply_switch_oe, // reference switch closed
  input wire logic [2:0] calibration_loop_switches, // loop switches
  input wire logic cal_feedback_en, // calibration feedback
  input wire logic [15:0] applied_code // code on modulator
);
  logic pdn_r;
  logic arn_r;
  logic cs_r;
  // pull levels: standby pulls low, reset and select pull high
  assign pdn_r = !power_down_n_float && power_down_n_pin;
  assign arn_r = async_reset_n_float || async_reset_n_pin;
  assign cs_r = cs_n_float || cs_n_pin;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  // wake-up: standby released with register reset inactive
  sequence s_wake;
    $rose(pdn_r) && arn_r && !cal_feedback_en;
  endsequence
  sequence s_cal_on;
    ##[1:4] cal_feedback_en;
  endsequence
  a_ref_switch: assert property (reference_supply_switch_oe == ($past(pdn_r) && $past(arn_r)))
    else $error("reference switch disagrees with pins");
  a_loop_legal: assert property (calibration_loop_switches inside {3'b000, 3'b111})
    else $error("loop switches split");
  a_loop_feedback: assert property (cal_feedback_en == (calibration_loop_switches == 3'b000))
    else $error("feedback and loop switches disagree");
  a_code_frozen: assert property (cal_feedback_en && $past(cal_feedback_en) && arn_r |-> $stable(applied_code))
    else $error("applied code moved during calibration");
  a_wake_launch: assert property (s_wake |-> s_cal_on)
    else $error("no calibration after wake-up");
  a_standby_idle: assert property (!pdn_r [*3] |-> !cal_feedback_en)
    else $error("calibration while in standby");
  a_regreset_idle: assert property (!arn_r [*3] |-> !cal_feedback_en)
    else $error("calibration while register reset low");
  a_sdout_quiet: assert property (cs_r [*3] |-> !sdout_oe)
    else $error("serial out driven while deselected");
endmodule : doac_top_asserts
////////////////////////////////////////////////////////////////
bind doac_top doac_top_asserts #(.STEP_CYCLES(STEP_CYCLES)) doac_top_asserts_i (.core_clk(core_clk),
  .arst_n(arst_n), .async_reset_n_pin(async_reset_n_pin), .async_reset_n_float(async_reset_n_float),
  .power_down_n_pin(power_down_n_pin), .power_down_n_float(power_down_n_float), .cs_n_pin(cs_n_pin),
  .cs_n_float(cs_n_float), .sdout_oe(sdout_oe), .reference_supply_switch_oe(reference_supply_switch_oe),
  .calibration_loop_switches(calibration_loop_switches), .cal_feedback_en(cal_feedback_en),
  .applied_code(applied_code));

//--- dv/doac_spi_master.sv
// Purpose: serial bus master model, one 24-bit frame per call
// Assumes: sclk half period of 6 core_clk cycles, above the 2-cycle minimum
// Notes: releases all its lines between frames so the pulls take over
`timescale 1ns/1ns
module doac_spi_master (
  input wire logic core_clk, // system clock
  output logic cs_n_pin, // select level
  output logic cs_n_float, // select released
  output logic sclk_pin, // serial clock level
  output logic sclk_float, // serial clock released
  output logic sdin_pin, // serial data level
  output logic sdin_float, // serial data released
  input wire logic sdout, // device serial out
  input wire logic sdout_oe // device serial out enable
);
  localparam int HALF = 6;
  logic sdo_line;
  // board pull-down holds the line low once the device lets go
  assign sdo_line = sdout_oe ? sdout : 1'b0;
  initial begin
    {cs_n_pin, sclk_pin, sdin_pin} = 3'b100;
    {cs_n_float, sclk_float, sdin_float} = 3'b111;
  end
  // header then data, msb first; read bits taken at each data-phase sclk rise
  task automatic xfer(input logic [7:0] hdr, input logic [15:0] wdata, output logic [15:0] rdata);
    logic [23:0] frame;
    frame = {hdr, wdata};
    rdata = 16'h0000;
    @(negedge core_clk);
    {cs_n_pin, cs_n_float, sclk_float, sdin_float} = 4'h0;
    for (int i = 23; i >= 0; i--) begin
      sdin_pin = frame[i];
      repeat (HALF) @(negedge core_clk);
      sclk_pin = 1'b1;
      if (i < 16) rdata = {rdata[14:0], sdo_line};
      repeat (HALF) @(negedge core_clk);
      sclk_pin = 1'b0;
    end
    repeat (HALF) @(negedge core_clk);
    {cs_n_pin, cs_n_float, sclk_float, sdin_float} = 4'hf;
    sdin_pin = ~sdin_pin;
    repeat (3) @(negedge core_clk);
  endtask : xfer
endmodule : doac_spi_master

//--- dv/testbench.sv
// Purpose: self-checking bench for the calibration control
// Assumes: short correction step so a full calibration stays brief
// Notes: inputs change on the falling clock edge
`timescale 1ns/1ns
module testbench;
  logic core_clk, arst_n, arn_pin, arn_float, pdn_pin, pdn_float, offset_high;
  wire cs_pin, cs_float, sck_pin, sck_float, sdi_pin, sdi_float, sdout, sdout_oe, ref_sw, ref_oe, fb_en;
  wire [2:0] loop_sw;
  wire [15:0] code;
  wire [7:0] corr;
  int errors, tests_run;
  logic [15:0] rd;
  always #5 core_clk = ~core_clk;
  doac_top #(.STEP_CYCLES(20)) doac_top_i (.core_clk(core_clk), .arst_n(arst_n), .async_reset_n_pin(arn_pin),
    .async_reset_n_float(arn_float), .power_down_n_pin(pdn_pin), .power_down_n_float(pdn_float),
    .cs_n_pin(cs_pin), .cs_n_float(cs_float), .sclk_pin(sck_pin), .sclk_float(sck_float), .sdin_pin(sdi_pin),
    .sdin_float(sdi_float), .offset_high(offset_high), .sdout(sdout), .sdout_oe(sdout_oe),
    .reference_supply_switch(ref_sw), .reference_supply_switch_oe(ref_oe), .calibration_loop_switches(loop_sw),
    .cal_feedback_en(fb_en), .applied_code(code), .applied_correction(corr));
  doac_spi_master doac_spi_master_i (.core_clk(core_clk), .cs_n_pin(cs_pin), .cs_n_float(cs_float),
    .sclk_pin(sck_pin), .sclk_float(sck_float), .sdin_pin(sdi_pin), .sdin_float(sdi_float), .sdout(sdout),
    .sdout_oe(sdout_oe));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic conclude;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] unused;
    doac_spi_master_i.xfer({1'b0, a}, d, unused);
  endtask : wr
  task automatic rdr(input logic [6:0] a);
    doac_spi_master_i.xfer({1'b1, a}, 16'h0000, rd);
  endtask : rdr
  // bounded wait for the feedback to drop; a run that outlasts the bound fails the check and ends the bench
  task automatic wait_cal_end(input int bound);
    int n;
    n = 0;
    while (fb_en !== 1'b0 && n < bound) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= bound) begin
      check(fb_en, 1'b0);
      conclude();
    end
  endtask : wait_cal_end
  ////////////////////////////////////////////////////////////////
  task automatic t_float;
    check({loop_sw, fb_en, ref_oe}, 5'h1c);
    check(code, 16'h0000);
    check(corr, 8'h80);
  endtask : t_float
  task automatic t_ref_table;
    {arn_float, pdn_float} = 2'b00;
    for (int i = 0; i < 4; i++) begin
      {pdn_pin, arn_pin} = i[1:0];
      repeat (3) @(negedge core_clk);
      check({ref_sw, ref_oe}, {2{i == 3}});
    end
  endtask : t_ref_table
  task automatic t_wake;
    pdn_pin = 1'b0;
    repeat (4) @(negedge core_clk);
    pdn_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    check(fb_en, 1'b1);
    wait_cal_end(4000);
    rdr(7'h01);
    check(rd[0], 1'b1);
    rdr(7'h01);
    check(rd[0], 1'b0);
  endtask : t_wake
  task automatic t_launch;
    wr(7'h02, 16'h8000);
    wr(7'h01, 16'h0002);
    check({loop_sw, fb_en}, 4'h1);
    wr(7'h02, 16'h1234);
    check(code, 16'h8000);
    wr(7'h01, 16'h0002);
    rdr(7'h01);
    check(rd[1:0], 2'b00);
    wait_cal_end(2000);
    check(corr, 8'h00);
    check({loop_sw, code}, {3'b111, 16'h1234});
    rdr(7'h01);
    check({rd[15:8], rd[0]}, 9'h001);
  endtask : t_launch
  // converge inside the range, then run into the positive limit
  task automatic t_converge;
    int n;
    offset_high = 1'b0;
    wr(7'h02, 16'h8000);
    wr(7'h01, 16'h0002);
    n = 0;
    while (corr !== 8'h83 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 400) begin
      check(corr, 8'h83);
      conclude();
    end
    offset_high = 1'b1;
    wait_cal_end(100);
    check({fb_en, corr}, 9'h083);
    rdr(7'h01);
    check({rd[15:8], rd[0]}, 9'h107);
    offset_high = 1'b0;
    wr(7'h01, 16'h0002);
    check(fb_en, 1'b1);
    wait_cal_end(3000);
    check(corr, 8'hff);
    offset_high = 1'b1;
  endtask : t_converge
  task automatic t_refused;
    arn_pin = 1'b0;
    wr(7'h02, 16'habcd);
    rdr(7'h02);
    check(rd, 16'h0000);
    arn_pin = 1'b1;
    rdr(7'h02);
    check(rd, 16'h0000);
    pdn_pin = 1'b0;
    wr(7'h01, 16'h00fe);
    check(fb_en, 1'b0);
    rdr(7'h01);
    check(rd[7:0], 8'hfc);
    rdr(7'h7f);
    check(rd, 16'h0000);
  endtask : t_refused
  ////////////////////////////////////////////////////////////////
  initial begin
    {core_clk, arst_n, arn_pin, pdn_pin, offset_high} = 5'b00001;
    {arn_float, pdn_float} = 2'b11;
    errors = 0;
    tests_run = 0;
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    t_float();
    t_ref_table();
    t_wake();
    t_launch();
    t_converge();
    t_refused();
    conclude();
  end
endmodule : testbench
